// *** ccd_exec.v ***
// What this block does
// RULE_01: watchdog clear op zeroes watchdog counter
// RULE_02: also zero prescaler when assigned to watchdog
// RULE_03: watchdog clear sets timeout, powerdown flags only
// RULE_04: file clear writes 00h, sets zero flag
// RULE_05: file invert complements register, updates zero flag
// RULE_06: destination bit 0 to working, 1 to file
// RULE_07: file decrement subtracts one, updates zero flag
`include "ccd_consts.vh"

module ccd_exec (
    mclk,
    resetn,
    instr_word,
    instr_valid,
    file_rdata,
    prescaler_on_watchdog,
    file_addr,
    file_wdata,
    file_we,
    work_q,
    status_q,
    watchdog_clear,
    prescaler_clear
);
    input wire mclk;
    input wire resetn;
    input wire [11:0] instr_word;
    input wire instr_valid;
    input wire [7:0] file_rdata;
    input wire prescaler_on_watchdog;
    output wire [4:0] file_addr;
    output reg [7:0] file_wdata;
    output reg file_we;
    output reg [7:0] work_q;
    output reg [7:0] status_q;
    output reg watchdog_clear;
    output reg prescaler_clear;

    // ****************************************
    // decode
    // ****************************************
    // one matcher serves all four opcode checks
    function op_match;
        input [11:0] word;
        input [11:0] pat;
        input [11:0] mask;
        begin
            op_match = ((word & mask) == pat);
        end
    endfunction

    wire is_wdt_clear;
    wire is_file_clear;
    wire is_file_invert;
    wire is_file_dec;
    wire dest_file;
    assign is_wdt_clear = instr_valid & op_match(instr_word, `CCD_OP_WDT_CLEAR, `CCD_MASK_FULL);
    assign is_file_clear = instr_valid
        & op_match(instr_word, `CCD_OP_FILE_CLEAR, `CCD_MASK_FILE_CLEAR);
    assign is_file_invert = instr_valid
        & op_match(instr_word, `CCD_OP_FILE_INVERT, `CCD_MASK_FILE_OP);
    assign is_file_dec = instr_valid & op_match(instr_word, `CCD_OP_FILE_DEC, `CCD_MASK_FILE_OP);
    assign dest_file = instr_word[`CCD_DEST_BIT];
    // address is combinational so the register file answers in the same cycle
    assign file_addr = instr_word[`CCD_FADDR_MSB:0];

    // ****************************************
    // result path
    // ****************************************
    reg [7:0] result;
    reg has_result;
    reg to_file;
    // one mux fed by a decrementer; decrement wraps 00h to ffh like the core alu
    always @*
    begin
        result = 8'h00;
        has_result = 1'b0;
        to_file = 1'b0;
        if (is_file_clear)
        begin
            result = 8'h00; // [RULE_04]
            has_result = 1'b1;
            to_file = 1'b1; // clear always targets the file
        end
        else if (is_file_invert)
        begin
            result = ~file_rdata; // [RULE_05]
            has_result = 1'b1;
            to_file = dest_file; // [RULE_06]
        end
        else if (is_file_dec)
        begin
            result = file_rdata - 8'h01; // [RULE_07]
            has_result = 1'b1;
            to_file = dest_file; // [RULE_06]
        end
    end

    // ****************************************
    // next-state values
    // ****************************************
    // next values are gathered here so each register block stays a plain copy
    wire zero_d;
    wire wdt_clear_d;
    wire pre_clear_d;
    wire file_we_d;
    wire [7:0] file_wdata_d;
    reg [7:0] work_d;
    wire [7:0] status_d;
    // zero flag is judged on the result, not on the old file value
    assign zero_d = (result == 8'h00); // [RULE_04] [RULE_05] [RULE_07]
    // watchdog strobe follows the decode directly
    assign wdt_clear_d = is_wdt_clear; // [RULE_01]
    // prescaler only follows when it is lent to the watchdog
    assign pre_clear_d = is_wdt_clear & prescaler_on_watchdog; // [RULE_02]
    // file write port; data is don't-care while the enable is low
    assign file_we_d = has_result & to_file; // [RULE_06]
    assign file_wdata_d = result;

    // working register takes only results routed away from the file
    always @*
    begin
        work_d = work_q;
        if (has_result && !to_file)
        begin
            work_d = result; // [RULE_06]
        end
    end

    // ****************************************
    // status next value, bit by bit
    // ****************************************
    // each bit picks its own source; bits that no op names simply hold
    // the decode is one-hot, so the zero and watchdog paths never collide
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_status
            if (g == `CCD_STAT_Z)
            begin : g_zero
                assign status_d[g] = has_result ? zero_d : status_q[g]; // [RULE_04] [RULE_05]
            end
            else if ((g == `CCD_STAT_TO) || (g == `CCD_STAT_PD))
            begin : g_wdt
                assign status_d[g] = is_wdt_clear ? 1'b1 : status_q[g]; // [RULE_03]
            end
            else
            begin : g_hold
                assign status_d[g] = status_q[g]; // [RULE_03]
            end
        end
    endgenerate

    // ****************************************
    // watchdog control pulses
    // ****************************************
    // one-cycle strobes; the watchdog itself does the counting
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            watchdog_clear <= 1'b0;
            prescaler_clear <= 1'b0;
        end
        else
        begin
            watchdog_clear <= wdt_clear_d; // [RULE_01]
            prescaler_clear <= pre_clear_d; // [RULE_02]
        end
    end

    // ****************************************
    // file write port
    // ****************************************
    // registered, so the write lands one cycle after the read it came from
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            file_we <= 1'b0;
            file_wdata <= 8'h00;
        end
        else
        begin
            file_we <= file_we_d; // [RULE_06]
            file_wdata <= file_wdata_d; // [RULE_04] [RULE_05] [RULE_07]
        end
    end

    // ****************************************
    // working register
    // ****************************************
    // holds unless a result is routed to it
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            work_q <= `CCD_W_RST;
        end
        else
        begin
            work_q <= work_d; // [RULE_06]
        end
    end

    // ****************************************
    // status register
    // ****************************************
    // this block holds all eight status bits; ops write only the zero, timeout and powerdown bits
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            status_q <= `CCD_STATUS_RST;
        end
        else
        begin
            status_q <= status_d; // [RULE_03] [RULE_07]
        end
    end
endmodule // ccd_exec

// *** ccd_consts.vh ***
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH
// ****************************************
// opcode patterns and masks (12-bit words)
// ****************************************
`define CCD_OP_WDT_CLEAR 12'h004
`define CCD_MASK_FULL 12'hfff
`define CCD_OP_FILE_CLEAR 12'h060
`define CCD_MASK_FILE_CLEAR 12'hfe0
`define CCD_OP_FILE_INVERT 12'h240
`define CCD_MASK_FILE_OP 12'hfc0
`define CCD_OP_FILE_DEC 12'h0c0
// ****************************************
// field positions
// ****************************************
`define CCD_DEST_BIT 5
`define CCD_FADDR_MSB 4
// ****************************************
// status bit positions and reset values
// ****************************************
`define CCD_STAT_Z 2
`define CCD_STAT_PD 3
`define CCD_STAT_TO 4
`define CCD_STATUS_RST 8'h18
`define CCD_W_RST 8'h00
`endif

// *** ccd_monitor.sv ***
module ccd_mon (
    input wire mclk,
    input wire resetn,
    input wire [11:0] instr_word,
    input wire instr_valid,
    input wire [7:0] file_rdata,
    input wire prescaler_on_watchdog,
    input wire [4:0] file_addr,
    input wire [7:0] file_wdata,
    input wire file_we,
    input wire [7:0] work_q,
    input wire [7:0] status_q,
    input wire watchdog_clear,
    input wire prescaler_clear
);
    // decoded requests, as the core would see them
    wire w = instr_valid && instr_word == 12'h004;
    wire c = instr_valid && (instr_word & 12'hfe0) == 12'h060;
    wire n = instr_valid && (instr_word & 12'hfc0) == 12'h240;
    wire e = instr_valid && (instr_word & 12'hfc0) == 12'h0c0;
    wire d = instr_word[5];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    wdt_clr_a: assert property (w |=> watchdog_clear) else $error("no clear");
    pre_clr_a: assert property (w |=> prescaler_clear == $past(prescaler_on_watchdog))
        else $error("bad prescaler");
    wdt_flags_a: assert property (w |=> status_q == {3'h0, 2'h3, $past(status_q[2]), 2'h0})
        else $error("bad flags");
    file_clr_a: assert property (c |=> file_we && file_wdata == 8'h00 && status_q[2])
        else $error("bad clear");
    inv_val_a: assert property (n && d |=> file_we && file_wdata == ~$past(file_rdata)
        && status_q[2] == ($past(file_rdata) == 8'hff)) else $error("bad invert");
    dest_w_a: assert property (e && !d |=> !file_we && work_q == $past(file_rdata) - 8'h01)
        else $error("bad dest");
    dec_z_a: assert property (e && d |=> file_wdata == $past(file_rdata) - 8'h01
        && status_q[2] == ($past(file_rdata) == 8'h01)) else $error("bad dec");
    addr_field_a: assert property (file_addr == instr_word[4:0]) else $error("bad addr");
endmodule // ccd_mon
bind ccd_exec ccd_mon m(.mclk, .resetn, .instr_word, .instr_valid, .file_rdata,
    .prescaler_on_watchdog, .file_addr, .file_wdata, .file_we, .work_q, .status_q, .watchdog_clear,
    .prescaler_clear);

// *** ccd_tb.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    reg mclk = 0, resetn = 0, instr_valid = 0, prescaler_on_watchdog = 0;
    reg [11:0] instr_word = 0, iw;
    reg [7:0] file_rdata = 0, w = 0, st = 8'h18, rd, wd, x;
    wire [4:0] file_addr;
    wire [7:0] file_wdata, work_q, status_q;
    wire file_we, watchdog_clear, prescaler_clear;
    wire [26:0] seen = {file_we, file_we ? file_wdata : 8'h00, work_q, status_q,
        watchdog_clear, prescaler_clear};
    reg [26:0] q[$], ex;
    reg [4:0] qa[$];
    reg [15:0] r = 16'hdf48;
    reg v, u, p, d, we, wc, pc;
    integer n_fail = 0, cmp_count = 0, i;
    always #25 mclk = ~mclk;
    ccd_exec uut(.mclk, .resetn, .instr_word, .instr_valid, .file_rdata,
        .prescaler_on_watchdog, .file_addr, .file_wdata, .file_we, .work_q, .status_q,
        .watchdog_clear, .prescaler_clear);
    function [15:0] nx(input [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task close_out;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task tally(input bad, input [26:0] e, input [26:0] a);
        cmp_count++;
        if (bad) begin n_fail++; $display("[ERR] %0t exp %h got %h", $time, e, a); end
    endtask
    // one compare per kind of result, all tallied alike
    task cmp_file(input [8:0] e, input [8:0] a); tally(a !== e, e, a); endtask
    task cmp_core(input [15:0] e, input [15:0] a); tally(a !== e, e, a); endtask
    task cmp_wdt(input [1:0] e, input [1:0] a); tally(a !== e, e, a); endtask
    task cmp_addr(input [4:0] e, input [4:0] a); tally(a !== e, e, a); endtask
    // results land one edge after the request, so the newest note waits a cycle
    always @(negedge mclk)
    begin
        // the address is combinational, so its note is due in the same cycle
        if (qa.size() > 0) cmp_addr(qa.pop_front(), file_addr);
        if (q.size() > 1)
        begin
            ex = q.pop_front();
            cmp_file(ex[26:18], seen[26:18]);
            cmp_core(ex[17:2], seen[17:2]);
            cmp_wdt(ex[1:0], seen[1:0]);
        end
    end
    initial begin #100us; n_fail++; close_out; end
    // random mix of the four ops, idle cycles and near-miss words
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            r = nx(nx(r));
            v = i > 0 && (r[9] | r[10]);
            u = v && !(r[13] & r[14]);
            p = r[12];
            d = r[7];
            rd = r[11] ? (r[0] ? 8'h01 : 8'hff) : r[15:8];
            case (r[1:0])
                0: iw = 12'h004;
                1: iw = {7'h03, r[6:2]};
                2: iw = {6'h09, d, r[6:2]};
                default: iw = {6'h03, d, r[6:2]};
            endcase
            if (!u) iw = iw ^ {v, 11'h0};
            {we, wc, pc, wd} = 0;
            if (u) case (r[1:0])
                0: begin st[4:3] = 2'h3; wc = 1; pc = p; end
                1: begin we = 1; st[2] = 1; end
                default: begin
                    x = r[1:0] == 2 ? ~rd : rd - 8'h01;
                    st[2] = x == 0;
                    if (d) {we, wd} = {1'b1, x}; else w = x;
                end
            endcase
            instr_valid <= v;
            instr_word <= iw;
            file_rdata <= rd;
            prescaler_on_watchdog <= p;
            q.push_back({we, wd, w, st, wc, pc});
            qa.push_back(iw[4:0]);
        end
        // one idle note lets the last real note reach the comparator
        @(posedge mclk);
        instr_valid <= 0;
        q.push_back({9'h000, w, st, 2'h0});
        repeat (2) @(posedge mclk);
        close_out;
    end
endmodule // testbench
